// File: rtl/rsq_pkg.sv
// constants and types of the reset and start-up sequencer
package rsq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS = 64;
  localparam int unsigned RC_OSC_HZ = 32_000;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS = (POWERUP_DELAY_TIMER_MS * RC_OSC_HZ) / 1000;
  localparam int unsigned BIAS_DELAY_US = 10;
  localparam int unsigned BIAS_DELAY_CYC = (BIAS_DELAY_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned OST_CYCLES = 1024;
  localparam int unsigned PIN_FILT_CYCLES = 8;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IDX_CAUSE = 12'h08e;
  localparam logic [ADDR_W-1:0] IDX_CFG = 12'h080;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h081;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h082;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_TO_BIT = 1;
  localparam int unsigned CAUSE_PD_BIT = 2;
  localparam int unsigned CFG_POWERUP_DELAY_TIMER_DIS_BIT = 0;
  localparam int unsigned CFG_PIN_SEL_BIT = 1;
  localparam logic [1:0] CFG_RST = 2'h2;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pd_n;
    logic to_n;
    logic por_n;
  } rsq_cause_t;

  localparam rsq_cause_t CAUSE_POR = 3'h6;

  typedef struct packed {
    logic ot_rst;
    logic pin_rst;
    logic wdt_wake;
    logic wdt_rst;
    logic por;
  } rsq_event_t;

  typedef enum logic [2:0] {
    ST_SUPPLY,
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_PIN,
    ST_DELAY,
    ST_RUN,
    ST_SLEEP,
    ST_HOLD
  } rsq_state_t;

endpackage : rsq_pkg

// File: rtl/rsq_pin_filter.sv
// synchroniser and glitch filter for the external reset pin
`timescale 1ns/1ps
module rsq_pin_filter
  import rsq_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = PIN_FILT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pin_n,
  input wire logic enable,
  output logic pin_low_q
);

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic [7:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_n;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // level must stay changed for FILT_CYCLES before it is accepted
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= 1'b1;
      cnt_q <= 8'h00;
    end else if (sync2_q == level_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(FILT_CYCLES - 1)) begin
      level_q <= sync2_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // pin acts as reset only when selected
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= enable & ~level_q;
    end
  end

endmodule // rsq_pin_filter

// File: rtl/rsq_top.sv
// reset source combiner and start-up sequencer with axi4-lite registers
`timescale 1ns/1ps

// Summary of operation
// - chip reset comes from power-on, overtemperature, reset pin or watchdog time-out
// - power-up timer holds reset 64 ms, only after power-on reset
// - config bit set disables power-up timer; cleared enables it
// - power-up timer counts ticks of a separate rc oscillator
// - start order: power-up timer, oscillator start-up timer, then pin release
// - time-outs run from power-on; late pin release starts execution after the about 10 us delay
// - about 10 us delay before execution after power-on or wake-up
// - pin select 0: pin ignored; 1: active-low reset input with pull-up
// - reset pin path filters out short low pulses
// - watchdog reset never drives the reset pin; pin stays input
// - most registers reset on power-on, pin and watchdog resets
// - watchdog time-out in sleep wakes without register reset
// - cause flags follow the documented table per reset kind
// - clear instruction in time avoids watchdog reset; else flags mark it
// - status register holds cause bits of the most recent reset
// - power-on reset held until supply is reported adequate
// - every reset clears the program counter
module rsq_top
  import rsq_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_COUNT = POWERUP_DELAY_TIMER_TICKS,
  parameter int unsigned OST_COUNT = OST_CYCLES,
  parameter int unsigned DELAY_COUNT = BIAS_DELAY_CYC,
  parameter int unsigned FILT_COUNT = PIN_FILT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic supply_ok,
  input wire logic overtemp_reset,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic rc_osc_clk,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_req,
  input wire logic wake_irq,
  output logic reg_reset_n,
  output logic pc_clear,
  output logic exec_enable,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic rst_pin_pullup_en,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rsq_state_t state_q;
  rsq_state_t state_d;
  rsq_cause_t cause_q;
  rsq_event_t ev;
  rsq_event_t irq_stat_q;
  rsq_event_t irq_mask_q;
  logic [1:0] cfg_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] sync3_q;
  logic pin_low;
  logic supply_good;
  logic ot_active;
  logic wdt_ev;
  logic rc_tick;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wbyte_q;
  logic aw_have_q;
  logic w_have_q;
  logic wr_go;
  logic rd_go;
  logic stat_rd;

  function automatic logic [ADDR_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = {2'h0, addr[ADDR_W-1:2]};
  endfunction

  function automatic logic cnt_done(input logic [CNT_W-1:0] cnt, input int unsigned lim);
    cnt_done = (cnt >= CNT_W'(lim - 1));
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 2'h0;
    end else begin
      sync1_q <= {rc_osc_clk, watchdog_timeout, overtemp_reset, supply_ok};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[3:2];
    end
  end

  assign supply_good = sync2_q[0];
  assign ot_active = sync2_q[1];
  assign wdt_ev = sync2_q[2] & ~sync3_q[0];
  assign rc_tick = sync2_q[3] & ~sync3_q[1];

  rsq_pin_filter #(
    .FILT_CYCLES(FILT_COUNT)
  ) u_pin_filter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_n(external_reset_pin_n),
    .enable(cfg_q[CFG_PIN_SEL_BIT]),
    .pin_low_q(pin_low)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SUPPLY: begin
        if (supply_good) begin
          state_d = cfg_q[CFG_POWERUP_DELAY_TIMER_DIS_BIT] ? ST_OST : ST_POWERUP_DELAY_TIMER;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (rc_tick && cnt_done(cnt_q, POWERUP_DELAY_TIMER_COUNT)) begin
          state_d = ST_OST;
        end
      end
      ST_OST: begin
        if (cnt_done(cnt_q, OST_COUNT)) begin
          state_d = ST_PIN;
        end
      end
      ST_PIN: begin
        if (!pin_low) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (ot_active) begin
          state_d = ST_HOLD;
        end else if (cnt_done(cnt_q, DELAY_COUNT)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pin_low || ot_active || wdt_ev) begin
          state_d = ST_HOLD;
        end else if (sleep_req) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (pin_low || ot_active) begin
          state_d = ST_HOLD;
        end else if (wdt_ev || wake_irq) begin
          state_d = ST_DELAY;
        end
      end
      ST_HOLD: begin
        if (!pin_low && !ot_active) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_SUPPLY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_SUPPLY;
    end else begin
      state_q <= state_d;
    end
  end

  // shared timer, restarted on every state change
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (state_q == ST_POWERUP_DELAY_TIMER) begin
      if (rc_tick) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end else if (state_q == ST_OST || state_q == ST_DELAY) begin
      if (!cnt_done(cnt_q, DELAY_COUNT + OST_COUNT)) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // chip reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_reset_n <= 1'b0;
      pc_clear <= 1'b1;
      exec_enable <= 1'b0;
    end else begin
      reg_reset_n <= !(state_d inside {ST_SUPPLY, ST_POWERUP_DELAY_TIMER, ST_OST, ST_PIN, ST_HOLD});
      pc_clear <= state_d inside {ST_SUPPLY, ST_POWERUP_DELAY_TIMER, ST_OST, ST_PIN, ST_HOLD};
      exec_enable <= (state_d == ST_RUN);
    end
  end

  // pin is never driven, only pulled up when selected
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
      rst_pin_pullup_en <= 1'b0;
    end else begin
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
      rst_pin_pullup_en <= cfg_q[CFG_PIN_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cause_q <= CAUSE_POR;
    end else begin
      if (wr_go && reg_index(awaddr_q) == IDX_CAUSE && wbyte_q) begin
        cause_q.por_n <= wdata_q[CAUSE_POR_BIT];
      end
      case (state_q)
        ST_RUN: begin
          if (!pin_low && !ot_active && wdt_ev) begin
            cause_q.to_n <= 1'b0;
          end else if (!pin_low && !ot_active && sleep_req) begin
            cause_q.to_n <= 1'b1;
            cause_q.pd_n <= 1'b0;
          end else if (watchdog_clear_instr) begin
            cause_q.to_n <= 1'b1;
            cause_q.pd_n <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (pin_low) begin
            cause_q.to_n <= 1'b1;
            cause_q.pd_n <= 1'b0;
          end else if (!ot_active && wdt_ev) begin
            cause_q.to_n <= 1'b0;
            cause_q.pd_n <= 1'b0;
          end else if (!ot_active && wake_irq) begin
            cause_q.to_n <= 1'b1;
            cause_q.pd_n <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt events, sticky status, mask
  // ----------------------------------------------------------------
  always_comb begin
    ev.por = (state_q == ST_PIN) && (state_d == ST_DELAY);
    ev.wdt_rst = (state_q == ST_RUN) && (state_d == ST_HOLD) && wdt_ev && !pin_low && !ot_active;
    ev.wdt_wake = (state_q == ST_SLEEP) && (state_d == ST_DELAY) && wdt_ev;
    ev.pin_rst = (state_q inside {ST_RUN, ST_SLEEP}) && pin_low;
    ev.ot_rst = (state_q != ST_HOLD) && (state_d == ST_HOLD) && ot_active;
  end

  assign stat_rd = rd_go && reg_index(s_axi_araddr) == IDX_IRQ_STAT;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? rsq_event_t'(5'h00) : irq_stat_q) | ev;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= IRQ_MASK_RST;
      cfg_q <= CFG_RST;
    end else if (wr_go && wbyte_q) begin
      if (reg_index(awaddr_q) == IDX_IRQ_MASK) begin
        irq_mask_q <= wdata_q[4:0];
      end
      if (reg_index(awaddr_q) == IDX_CFG) begin
        cfg_q <= wdata_q[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_q | ev) & irq_mask_q & ~(stat_rd ? 5'h1f : 5'h00));
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wbyte_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wbyte_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_index(awaddr_q) inside {IDX_CAUSE, IDX_CFG, IDX_IRQ_STAT,
                        IDX_IRQ_MASK}) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (reg_index(s_axi_araddr))
          IDX_CAUSE: s_axi_rdata <= {29'h0, cause_q};
          IDX_CFG: s_axi_rdata <= {30'h0, cfg_q};
          IDX_IRQ_STAT: s_axi_rdata <= {27'h0, irq_stat_q};
          IDX_IRQ_MASK: s_axi_rdata <= {27'h0, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rsq_top

// File: sim/rsq_top_properties.sv
// concurrent checks of the reset and start-up sequencer ports
`timescale 1ns/1ps
module rsq_top_properties
  import rsq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic supply_ok,
  input wire logic overtemp_reset,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic reg_reset_n,
  input wire logic pc_clear,
  input wire logic exec_enable,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic rst_pin_pullup_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // ----------------------------------------------------------------
  // helper: start-up after power-on still pending
  // ----------------------------------------------------------------
  logic por_phase_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_phase_q <= 1'b1;
    end else if (exec_enable) begin
      por_phase_q <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_pc_clear; pc_clear == !reg_reset_n; endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("pc not held with reset");
  property p_pin_input; !rst_pin_oe && !rst_pin_out; endproperty
  a_pin_input: assert property (p_pin_input) else $error("reset pin driven");
  property p_exec_regs; exec_enable |-> reg_reset_n; endproperty
  a_exec_regs: assert property (p_exec_regs) else $error("running in reset");
  property p_ot; overtemp_reset [*6] |-> !exec_enable; endproperty
  a_ot: assert property (p_ot) else $error("overtemp ignored");
  property p_pin; (!external_reset_pin_n && rst_pin_pullup_en) [*8] |=> !exec_enable;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_wdt; exec_enable && $rose(watchdog_timeout) |-> ##[1:8] !exec_enable;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog ignored");
  property p_supply; !supply_ok && !exec_enable |=> !exec_enable; endproperty
  a_supply: assert property (p_supply) else $error("ran on bad supply");
  property p_delay; por_phase_q && $rose(reg_reset_n) |-> !exec_enable [*8]; endproperty
  a_delay: assert property (p_delay) else $error("start delay too short");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
endmodule // rsq_top_properties

bind rsq_top rsq_top_properties u_props (.sys_clk, .rstn, .supply_ok, .overtemp_reset,
  .external_reset_pin_n, .watchdog_timeout, .reg_reset_n, .pc_clear, .exec_enable,
  .rst_pin_out, .rst_pin_oe, .rst_pin_pullup_en, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

// File: sim/rsq_ext_partner.sv
// reset pin circuit and watchdog source outside the sequencer
`timescale 1ns/1ps
module rsq_ext_partner (
  input wire logic sys_clk,
  input wire logic hold_low,
  input wire logic pullup_en,
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic wdt_fire,
  output logic pin_n,
  output logic wdt_timeout
);
  logic flip_q = 1'b0;
  logic [2:0] wdt_cnt_q = 3'h0;
  always_ff @(posedge sys_clk) begin
    flip_q <= !flip_q;
  end
  // pin level: device drive, button, pull-up, else floating
  always_comb begin
    if (pin_oe) begin
      pin_n = pin_out;
    end else if (hold_low) begin
      pin_n = 1'b0;
    end else if (pullup_en) begin
      pin_n = 1'b1;
    end else begin
      pin_n = flip_q;
    end
  end
  // expiry level held a few cycles
  always_ff @(posedge sys_clk) begin
    if (wdt_fire) begin
      wdt_cnt_q <= 3'h6;
    end else if (wdt_cnt_q != 3'h0) begin
      wdt_cnt_q <= wdt_cnt_q - 3'h1;
    end
  end
  assign wdt_timeout = (wdt_cnt_q != 3'h0);
endmodule // rsq_ext_partner

// File: sim/tb_rsq_top.sv
// self-checking bench of the reset and start-up sequencer
`timescale 1ns/1ps
module tb_rsq_top
  import rsq_pkg::*;
;
  logic sys_clk = 1'b0, rstn = 1'b0, rc_clk = 1'b0, supply_ok = 1'b0, ot = 1'b0;
  logic wclr = 1'b0, slp = 1'b0, wake = 1'b0, hold_low = 1'b0, wdt_fire = 1'b0;
  logic pin_n, wdt_to, reg_reset_n, pc_clear, exec_enable, pin_out, pin_oe, pullup_en, irq;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fails = 0, cmp_count = 0, cyc = 0, m_cause, n, rr_low = 0;

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #7;
    forever #200 rc_clk = ~rc_clk;
  end

  rsq_top #(.POWERUP_DELAY_TIMER_COUNT(4), .OST_COUNT(8), .DELAY_COUNT(10), .FILT_COUNT(3)) DUT (
    .sys_clk, .rstn, .supply_ok, .overtemp_reset(ot), .external_reset_pin_n(pin_n),
    .watchdog_timeout(wdt_to), .rc_osc_clk(rc_clk), .watchdog_clear_instr(wclr),
    .sleep_req(slp), .wake_irq(wake), .reg_reset_n, .pc_clear, .exec_enable,
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .rst_pin_pullup_en(pullup_en), .irq,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  rsq_ext_partner P (.sys_clk, .hold_low, .pullup_en, .pin_oe, .pin_out, .wdt_fire,
    .pin_n, .wdt_timeout(wdt_to));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reg_reset_n) rr_low <= rr_low + 1;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clk(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic wexec(input logic v);
    while (exec_enable !== v) @(posedge sys_clk);
  endtask

  task automatic pulse(input int k);
    repeat (2) begin
      case (k)
        0: slp <= !slp;
        1: wake <= !wake;
        2: wclr <= !wclr;
        3: wdt_fire <= !wdt_fire;
        default: hold_low <= !hold_low;
      endcase
      clk(1);
    end
  endtask

  task automatic axw(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] rsp);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= {idx[9:0], 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, rsp});
    bready <= 1'b0;
    clk(1);
  endtask

  task automatic axr(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] rsp);
    araddr <= {idx[9:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, rsp});
    rready <= 1'b0;
    clk(1);
  endtask

  task automatic sleep_now();
    pulse(0);
    wexec(1'b0);
    clk(2);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(32'h6778);
    clk(8);
    rstn <= 1'b1;
    clk(5);
    supply_ok <= 1'b1;
    n = 0;
    while (exec_enable !== 1'b1) begin
      clk(1);
      n++;
    end
    chk({31'h0, n > 60}, 1);
    m_cause = 6;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axr(IDX_CFG, 2, RESP_OKAY);
    axr(IDX_IRQ_STAT, 1, RESP_OKAY);
    axr(IDX_IRQ_STAT, 0, RESP_OKAY);
    axr(12'h010, 0, RESP_SLVERR);
    axw(12'h010, 1, RESP_SLVERR);
    n = $urandom & 32'h1f;
    axw(IDX_IRQ_MASK, n, RESP_OKAY);
    axr(IDX_IRQ_MASK, n, RESP_OKAY);
    axw(IDX_CAUSE, 1, RESP_OKAY);
    m_cause = 7;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    // watchdog reset while running, then clear
    pulse(3);
    wexec(1'b0);
    wexec(1'b1);
    m_cause = 5;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axw(IDX_IRQ_MASK, 32'h1f, RESP_OKAY);
    clk(2);
    chk({31'h0, irq}, 1);
    axr(IDX_IRQ_STAT, 2, RESP_OKAY);
    clk(2);
    chk({31'h0, irq}, 0);
    pulse(2);
    m_cause = 7;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    // short glitch, then a real pin reset while running
    n = rr_low;
    pulse(4);
    clk(12);
    chk(rr_low, n);
    hold_low <= 1'b1;
    clk(10);
    hold_low <= 1'b0;
    wexec(1'b1);
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axw(IDX_IRQ_MASK, 0, RESP_OKAY);
    clk(2);
    chk({31'h0, irq}, 0);
    axr(IDX_IRQ_STAT, 8, RESP_OKAY);
    // sleep, interrupt wake
    sleep_now();
    m_cause = 3;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    pulse(1);
    n = 0;
    while (exec_enable !== 1'b1) begin
      clk(1);
      n++;
    end
    chk({31'h0, n >= 8}, 1);
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    // sleep, watchdog wake without register reset
    sleep_now();
    n = rr_low;
    pulse(3);
    wexec(1'b1);
    chk(rr_low, n);
    m_cause = 1;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axr(IDX_IRQ_STAT, 4, RESP_OKAY);
    // sleep, pin reset
    sleep_now();
    hold_low <= 1'b1;
    clk(10);
    hold_low <= 1'b0;
    wexec(1'b1);
    m_cause = 3;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axr(IDX_IRQ_STAT, 8, RESP_OKAY);
    // overtemperature of random length
    ot <= 1'b1;
    wexec(1'b0);
    clk(5 + ($urandom % 16));
    ot <= 1'b0;
    wexec(1'b1);
    axr(IDX_IRQ_STAT, 32'h10, RESP_OKAY);
    // pin function off: pin ignored
    axw(IDX_CFG, 0, RESP_OKAY);
    clk(2);
    chk({31'h0, pullup_en}, 0);
    n = rr_low;
    hold_low <= 1'b1;
    clk(10);
    hold_low <= 1'b0;
    chk(rr_low, n);
    // power-on again with pin held past the time-outs
    hold_low <= 1'b1;
    rstn <= 1'b0;
    clk(2);
    rstn <= 1'b1;
    clk(300);
    chk({31'h0, exec_enable}, 0);
    hold_low <= 1'b0;
    n = 0;
    while (exec_enable !== 1'b1) begin
      clk(1);
      n++;
    end
    chk({31'h0, n <= 25}, 1);
    m_cause = 6;
    axr(IDX_CAUSE, m_cause, RESP_OKAY);
    axr(IDX_CFG, 2, RESP_OKAY);
    print_verdict();
  end
endmodule // tb_rsq_top
